// ==== verilog/spm_regs.svh ====
// Register indexes, field positions and reset values of the pin mux
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH
`define SPM_IDX_EXT_BUS_SEL 16'h1C00
`define SPM_IDX_PIN_LEVEL 16'h1C01
`define SPM_IDX_PD_INHIBIT_ONE 16'h1C17
`define SPM_IDX_PD_INHIBIT_TWO 16'h1C18
`define SPM_EXTERNAL_BUS_SELECT_ADDR_LSB 0
`define SPM_EXTERNAL_BUS_SELECT_SP0_LSB 8
`define SPM_EXTERNAL_BUS_SELECT_SP1_LSB 10
`define SPM_EXTERNAL_BUS_SELECT_SRC_CLK_BIT 15
`define SPM_EXTERNAL_BUS_SELECT_WMASK 16'h8F3F
`define SPM_EXTERNAL_BUS_SELECT_RESET 16'h0000
`define SPM_INHIBIT_ONE_WMASK 16'h3F3F
`define SPM_INHIBIT_TWO_WMASK 16'h003F
`define SPM_INHIBIT_RESET 16'h0000
`define SPM_PORT_ONE_PD_LSB 8
`define SPM_PORT_ZERO_PD_LSB 0
`define SPM_LEVEL_ONE_LSB 8
`endif

// ==== verilog/spm_pkg.sv ====
// Types shared by the pin mux files
package spm_pkg;
  typedef enum logic [1:0] {SPM_P1_CARD, SPM_P1_SPI, SPM_P1_GPIO, SPM_P1_UNUSED}
    spm_port_one_route_t;
  typedef enum logic [1:0] {SPM_P0_CARD, SPM_P0_AUDIO, SPM_P0_GPIO, SPM_P0_BUFFERED}
    spm_port_zero_route_t;
  typedef struct packed {logic [5:0] out; logic [5:0] drv;} spm_drv6_t;
  typedef struct packed {logic [3:0] out; logic [3:0] drv;} spm_drv4_t;
  typedef struct packed {logic [5:0] out; logic [5:0] oeN; logic [5:0] pdEn;} spm_pad6_t;
  typedef struct packed
  {
    logic [17:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } spm_apb_req_t;
  typedef struct packed {logic [31:0] prdata; logic pready; logic pslverr;} spm_apb_rsp_t;
  typedef struct packed
  {
    logic [15:0] extBusSel;
    logic [15:0] inhibitOne;
    logic [15:0] inhibitTwo;
  } spm_cfg_t;
  typedef struct packed {spm_apb_rsp_t rsp; spm_cfg_t cfg;} spm_apb_state_t;
  typedef struct packed
  {
    logic sync1;
    logic sync2;
    logic out;
    logic oeN;
    logic pdEn;
  } spm_cell_state_t;
  typedef struct packed
  {
    logic [5:0] cardOneIn;
    logic [5:0] spiIn;
    logic [5:0] gpioLowIn;
    logic [5:0] cardZeroIn;
    logic [3:0] audioIn;
    logic [5:0] gpioZeroIn;
    logic [4:0] bufIn;
    logic bufRxClk;
    logic bufSrcClk;
    logic [5:0] gpioUpperIn;
  } spm_mux_state_t;
endpackage

// ==== verilog/spm_pin_cell.sv ====
// One package pin: input synchroniser and registered drive
`timescale 1ns/1ps
module spm_pin_cell
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Pad side
  input wire logic padIn,
  output logic padOut,
  output logic padOeN,
  output logic padPdEn,
  // Core side
  input wire logic drvOut,
  input wire logic drvEn,
  input wire logic inhibit,
  output logic level
);
  import spm_pkg::*;

  spm_cell_state_t state_ff;
  spm_cell_state_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.sync1 = padIn;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.out = drvOut & drvEn;
    nxt_state.oeN = ~drvEn;
    nxt_state.pdEn = ~inhibit;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_ff <= '{sync1: 1'b0, sync2: 1'b0, out: 1'b0, oeN: 1'b1, pdEn: 1'b1};
    else
      state_ff <= nxt_state;
  end

  assign padOut = state_ff.out;
  assign padOeN = state_ff.oeN;
  assign padPdEn = state_ff.pdEn;
  assign level = state_ff.sync2;
endmodule

// ==== verilog/spm_apb_regs.sv ====
// APB slave holding the pin mux configuration registers
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_apb_regs
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB
  input wire spm_pkg::spm_apb_req_t apbReq,
  output spm_pkg::spm_apb_rsp_t apbRsp,
  // Core side
  input wire logic [15:0] pinLevel,
  output spm_pkg::spm_cfg_t cfg
);
  import spm_pkg::*;

  spm_apb_state_t state_ff;
  spm_apb_state_t nxt_state;
  logic hitSel;
  logic hitLvl;
  logic hitOne;
  logic hitTwo;

  assign hitSel = apbReq.paddr == {`SPM_IDX_EXT_BUS_SEL, 2'b00};
  assign hitLvl = apbReq.paddr == {`SPM_IDX_PIN_LEVEL, 2'b00};
  assign hitOne = apbReq.paddr == {`SPM_IDX_PD_INHIBIT_ONE, 2'b00};
  assign hitTwo = apbReq.paddr == {`SPM_IDX_PD_INHIBIT_TWO, 2'b00};

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rsp.pready = 1'b0;
    nxt_state.rsp.pslverr = 1'b0;
    // Setup phase: decode and answer in the next cycle
    if (apbReq.psel && !apbReq.penable)
    begin
      nxt_state.rsp.pready = 1'b1;
      nxt_state.rsp.pslverr = !(hitSel || hitLvl || hitOne || hitTwo) ||
        (apbReq.pwrite && hitLvl);
      nxt_state.rsp.prdata = 32'h0000_0000;
      if (!apbReq.pwrite)
      begin
        if (hitSel)
          nxt_state.rsp.prdata[15:0] = state_ff.cfg.extBusSel;
        if (hitLvl)
          nxt_state.rsp.prdata[15:0] = pinLevel;
        if (hitOne)
          nxt_state.rsp.prdata[15:0] = state_ff.cfg.inhibitOne;
        if (hitTwo)
          nxt_state.rsp.prdata[15:0] = state_ff.cfg.inhibitTwo;
      end
    end
    // Access phase: write lands at the edge where pready is seen
    if (apbReq.psel && apbReq.penable && apbReq.pwrite && state_ff.rsp.pready)
    begin
      if (hitSel)
        nxt_state.cfg.extBusSel = apbReq.pwdata[15:0] & `SPM_EXTERNAL_BUS_SELECT_WMASK;
      if (hitOne)
        nxt_state.cfg.inhibitOne = apbReq.pwdata[15:0] & `SPM_INHIBIT_ONE_WMASK;
      if (hitTwo)
        nxt_state.cfg.inhibitTwo = apbReq.pwdata[15:0] & `SPM_INHIBIT_TWO_WMASK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff.rsp <= '0;
      state_ff.cfg.extBusSel <= `SPM_EXTERNAL_BUS_SELECT_RESET;
      state_ff.cfg.inhibitOne <= `SPM_INHIBIT_RESET;
      state_ff.cfg.inhibitTwo <= `SPM_INHIBIT_RESET;
    end
    else
      state_ff <= nxt_state;
  end

  assign apbRsp = state_ff.rsp;
  assign cfg = state_ff.cfg;
endmodule

// ==== verilog/spm_pin_mux.sv ====
// Pin mux for serial port 1, serial port 0 and upper address pins
//
// What this block does
// - A two-bit port one field, reset 00, routes six pins to card one, multi SPI or GPIO 6-11.
// - In SPI mode pins 0-5 carry clock, select 0, ctrl out, ctrl in, select 1, select 2.
// - A two-bit port zero field, reset 00, picks card zero, audio, GPIO 0-5 or buffered port.
// - Audio mode puts clock, frame, tx, rx on pins 0-3; buffered mode uses all six pins.
// - In buffered mode bit 15 of the bus select register makes pin 5 rx clock or source clock.
// - Six single bits give address lines 15-20 either to memory or to GPIO 21-26.
// - Port one pin n has its pull-down governed by bit 8+n of the first inhibit register.
// - Port zero pin n has its pull-down governed by bit n of the first inhibit register.
// - Address pins 15-20 have their pull-downs governed by bits 0-5 of the second register.
// - One external bus select register holds all routing fields; pull-down inhibits sit in two further registers.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_pin_mux
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // APB register port
  input wire spm_pkg::spm_apb_req_t apbReq,
  output spm_pkg::spm_apb_rsp_t apbRsp,
  // Serial port 1 pads
  input wire logic [5:0] portOnePadIn,
  output spm_pkg::spm_pad6_t portOnePad,
  // Serial port 0 pads
  input wire logic [5:0] portZeroPadIn,
  output spm_pkg::spm_pad6_t portZeroPad,
  // Upper address pads
  input wire logic [5:0] addrPadIn,
  output spm_pkg::spm_pad6_t addrPad,
  // Card one controller
  input wire spm_pkg::spm_drv6_t cardOneDrv,
  output logic [5:0] cardOneIn,
  // Multi SPI controller
  input wire spm_pkg::spm_drv6_t spiDrv,
  output logic [5:0] spiIn,
  // GPIO 6 to 11
  input wire spm_pkg::spm_drv6_t gpioLowDrv,
  output logic [5:0] gpioLowIn,
  // Card zero controller
  input wire spm_pkg::spm_drv6_t cardZeroDrv,
  output logic [5:0] cardZeroIn,
  // Audio port zero
  input wire spm_pkg::spm_drv4_t audioDrv,
  output logic [3:0] audioIn,
  // GPIO 0 to 5
  input wire spm_pkg::spm_drv6_t gpioZeroDrv,
  output logic [5:0] gpioZeroIn,
  // Buffered serial port
  input wire spm_pkg::spm_drv6_t bufDrv,
  output logic [4:0] bufIn,
  output logic bufRxClk,
  output logic bufSrcClk,
  // Memory address and GPIO 21 to 26
  input wire logic [5:0] extMemUpperAddress,
  input wire spm_pkg::spm_drv6_t gpioUpperDrv,
  output logic [5:0] gpioUpperIn
);
  import spm_pkg::*;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  spm_cfg_t cfg;
  logic [5:0] p1Level;
  logic [5:0] p0Level;
  logic [5:0] addrLevel;
  logic [15:0] pinLevel;

  // ----------------------------------------
  // Pin level readback
  // ----------------------------------------
  always_comb
  begin
    // Port one at 13:8, port zero at 5:0
    pinLevel = 16'h0000;
    pinLevel[`SPM_LEVEL_ONE_LSB +: 6] = p1Level;
    pinLevel[5:0] = p0Level;
  end

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  spm_apb_regs u_regs
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .pinLevel(pinLevel),
    .cfg(cfg)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  spm_port_one_route_t portOneRouteField;
  spm_port_zero_route_t portZeroRouteField;
  logic [5:0] addrMode;
  logic srcClkSel;

  assign portOneRouteField =
    spm_port_one_route_t'(cfg.extBusSel[`SPM_EXTERNAL_BUS_SELECT_SP1_LSB +: 2]);
  assign portZeroRouteField =
    spm_port_zero_route_t'(cfg.extBusSel[`SPM_EXTERNAL_BUS_SELECT_SP0_LSB +: 2]);
  assign addrMode = cfg.extBusSel[`SPM_EXTERNAL_BUS_SELECT_ADDR_LSB +: 6];
  assign srcClkSel = cfg.extBusSel[`SPM_EXTERNAL_BUS_SELECT_SRC_CLK_BIT];

  // ----------------------------------------
  // Routing
  // ----------------------------------------
  spm_mux_state_t state_ff;
  spm_mux_state_t nxt_state;
  logic [5:0] p1Out;
  logic [5:0] p1Drv;
  logic [5:0] p0Out;
  logic [5:0] p0Drv;
  logic [5:0] aOut;
  logic [5:0] aDrv;

  always_comb
  begin
    // Unselected inputs read zero, pins released
    nxt_state = '0;
    p1Out = 6'h00;
    p1Drv = 6'h00;
    p0Out = 6'h00;
    p0Drv = 6'h00;
    aOut = 6'h00;
    aDrv = 6'h00;

    // Serial port 1
    unique case (portOneRouteField)
      SPM_P1_CARD:
      begin
        p1Out = cardOneDrv.out;
        p1Drv = cardOneDrv.drv;
        nxt_state.cardOneIn = p1Level;
      end
      SPM_P1_SPI:
      begin
        // Clock, select 0, ctrl out, ctrl in, select 1, select 2
        p1Out = spiDrv.out;
        p1Drv = spiDrv.drv;
        nxt_state.spiIn = p1Level;
      end
      SPM_P1_GPIO:
      begin
        p1Out = gpioLowDrv.out;
        p1Drv = gpioLowDrv.drv;
        nxt_state.gpioLowIn = p1Level;
      end
      SPM_P1_UNUSED:
      begin
        // Pins released, nobody listens
        p1Out = 6'h00;
        p1Drv = 6'h00;
      end
    endcase

    // Serial port 0
    unique case (portZeroRouteField)
      SPM_P0_CARD:
      begin
        p0Out = cardZeroDrv.out;
        p0Drv = cardZeroDrv.drv;
        nxt_state.cardZeroIn = p0Level;
      end
      SPM_P0_AUDIO:
      begin
        // Pins 4 and 5 stay with GPIO
        p0Out = {gpioZeroDrv.out[5:4], audioDrv.out};
        p0Drv = {gpioZeroDrv.drv[5:4], audioDrv.drv};
        nxt_state.audioIn = p0Level[3:0];
        nxt_state.gpioZeroIn[5:4] = p0Level[5:4];
      end
      SPM_P0_GPIO:
      begin
        p0Out = gpioZeroDrv.out;
        p0Drv = gpioZeroDrv.drv;
        nxt_state.gpioZeroIn = p0Level;
      end
      SPM_P0_BUFFERED:
      begin
        // Tx clock, tx frame, tx data, rx data, rx frame
        p0Out = bufDrv.out;
        p0Drv = bufDrv.drv;
        nxt_state.bufIn = p0Level[4:0];
        // Pin 5 feeds one of two clock inputs
        if (srcClkSel)
          nxt_state.bufSrcClk = p0Level[5];
        else
          nxt_state.bufRxClk = p0Level[5];
      end
    endcase

    // Upper address pins, one bit each
    for (int i = 0; i < 6; i++)
    begin
      if (addrMode[i])
      begin
        aOut[i] = gpioUpperDrv.out[i];
        aDrv[i] = gpioUpperDrv.drv[i];
        nxt_state.gpioUpperIn[i] = addrLevel[i];
      end
      else
      begin
        // Memory address always drives its pin
        aOut[i] = extMemUpperAddress[i];
        aDrv[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Input route register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  // ----------------------------------------
  // Peripheral inputs
  // ----------------------------------------
  assign cardOneIn = state_ff.cardOneIn;
  assign spiIn = state_ff.spiIn;
  assign gpioLowIn = state_ff.gpioLowIn;
  assign cardZeroIn = state_ff.cardZeroIn;
  assign audioIn = state_ff.audioIn;
  assign gpioZeroIn = state_ff.gpioZeroIn;
  assign bufIn = state_ff.bufIn;
  assign bufRxClk = state_ff.bufRxClk;
  assign bufSrcClk = state_ff.bufSrcClk;
  assign gpioUpperIn = state_ff.gpioUpperIn;

  // ----------------------------------------
  // Serial port 1 pins
  // ----------------------------------------
  for (genvar n = 0; n < 6; n++)
  begin : g_one
    spm_pin_cell u_one
    (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .padIn(portOnePadIn[n]),
      .padOut(portOnePad.out[n]),
      .padOeN(portOnePad.oeN[n]),
      .padPdEn(portOnePad.pdEn[n]),
      .drvOut(p1Out[n]),
      .drvEn(p1Drv[n]),
      .inhibit(cfg.inhibitOne[`SPM_PORT_ONE_PD_LSB + n]),
      .level(p1Level[n])
    );
  end

  // ----------------------------------------
  // Serial port 0 pins
  // ----------------------------------------
  for (genvar n = 0; n < 6; n++)
  begin : g_zero
    spm_pin_cell u_zero
    (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .padIn(portZeroPadIn[n]),
      .padOut(portZeroPad.out[n]),
      .padOeN(portZeroPad.oeN[n]),
      .padPdEn(portZeroPad.pdEn[n]),
      .drvOut(p0Out[n]),
      .drvEn(p0Drv[n]),
      .inhibit(cfg.inhibitOne[`SPM_PORT_ZERO_PD_LSB + n]),
      .level(p0Level[n])
    );
  end

  // ----------------------------------------
  // Upper address pins
  // ----------------------------------------
  for (genvar n = 0; n < 6; n++)
  begin : g_addr
    spm_pin_cell u_addr
    (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .padIn(addrPadIn[n]),
      .padOut(addrPad.out[n]),
      .padOeN(addrPad.oeN[n]),
      .padPdEn(addrPad.pdEn[n]),
      .drvOut(aOut[n]),
      .drvEn(aDrv[n]),
      .inhibit(cfg.inhibitTwo[n]),
      .level(addrLevel[n])
    );
  end
endmodule

// ==== dv/spm_pin_mux_properties.sv ====
// Checker of register access and pad routing of the pin mux
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_pin_mux_properties
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Watched ports
  input wire spm_pkg::spm_apb_req_t apbReq,
  input wire spm_pkg::spm_apb_rsp_t apbRsp,
  input wire logic [5:0] portZeroPadIn,
  input wire spm_pkg::spm_pad6_t portOnePad,
  input wire spm_pkg::spm_pad6_t portZeroPad,
  input wire spm_pkg::spm_pad6_t addrPad,
  input wire spm_pkg::spm_drv6_t cardOneDrv,
  input wire spm_pkg::spm_drv6_t spiDrv,
  input wire spm_pkg::spm_drv6_t bufDrv,
  input wire logic [5:0] extMemUpperAddress,
  input wire spm_pkg::spm_drv6_t gpioUpperDrv,
  input wire logic bufRxClk,
  input wire logic bufSrcClk
);
  import spm_pkg::*;
  logic [15:0] ebs_ff, inh1_ff, inh2_ff;
  logic wr;
  assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
  // Mirror of the configuration registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ebs_ff <= 16'h0000;
      inh1_ff <= 16'h0000;
      inh2_ff <= 16'h0000;
    end
    else if (wr)
    begin
      if (apbReq.paddr == 18'h07000)
        ebs_ff <= apbReq.pwdata[15:0] & `SPM_EXTERNAL_BUS_SELECT_WMASK;
      if (apbReq.paddr == 18'h0705C)
        inh1_ff <= apbReq.pwdata[15:0];
      if (apbReq.paddr == 18'h07060)
        inh2_ff <= apbReq.pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  property p_ready;
    s_setup |=> apbRsp.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_unmapped;
    s_setup ##0 !(apbReq.paddr inside {18'h07000, 18'h07004, 18'h0705C, 18'h07060})
      |=> apbRsp.pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_one_card;
    $past(resetn) && $past(ebs_ff[11:10]) == 2'b00
      |-> portOnePad.oeN == ~$past(cardOneDrv.drv);
  endproperty
  a_one_card: assert property (p_one_card) else $error("card one drive");
  property p_one_spi;
    $past(ebs_ff[11:10]) == 2'b01 |-> portOnePad.out == $past(spiDrv.out & spiDrv.drv);
  endproperty
  a_one_spi: assert property (p_one_spi) else $error("spi pin order");
  property p_one_unused;
    $past(ebs_ff[11:10]) == 2'b11 |-> portOnePad.oeN == 6'h3F;
  endproperty
  a_one_unused: assert property (p_one_unused) else $error("unused code drives");
  property p_zero_buf;
    $past(ebs_ff[9:8]) == 2'b11 |-> portZeroPad.oeN == ~$past(bufDrv.drv);
  endproperty
  a_zero_buf: assert property (p_zero_buf) else $error("buffered port drive");
  property p_addr;
    $past(resetn) |-> addrPad.out
      == (($past(ebs_ff[5:0]) & $past(gpioUpperDrv.out & gpioUpperDrv.drv))
      | (~$past(ebs_ff[5:0]) & $past(extMemUpperAddress)));
  endproperty
  a_addr: assert property (p_addr) else $error("address pin route");
  property p_pd;
    {portOnePad.pdEn, portZeroPad.pdEn, addrPad.pdEn}
      == ~{$past(inh1_ff[13:8]), $past(inh1_ff[5:0]), $past(inh2_ff[5:0])};
  endproperty
  a_pd: assert property (p_pd) else $error("pull-down enable");
  property p_src;
    $past({ebs_ff[15], ebs_ff[9:8]}) == 3'b111
      |-> bufSrcClk == $past(portZeroPadIn[5], 3) && !bufRxClk;
  endproperty
  a_src: assert property (p_src) else $error("pin 5 clock select");
endmodule
bind spm_pin_mux spm_pin_mux_properties i_props (.clk_sys, .resetn, .apbReq, .apbRsp,
  .portZeroPadIn, .portOnePad, .portZeroPad, .addrPad, .cardOneDrv, .spiDrv, .bufDrv,
  .extMemUpperAddress, .gpioUpperDrv, .bufRxClk, .bufSrcClk);

// ==== dv/spm_pad_model.sv ====
// Board side of six pads: loop back, outside drive, pull-down or toggling
`timescale 1ns/1ps
module spm_pad_model
  import spm_pkg::*;
(
  // Pads
  input wire logic clk_sys,
  input wire spm_pkg::spm_pad6_t pad,
  // Outside driver
  input wire logic [5:0] extVal,
  input wire logic [5:0] extEn,
  output logic [5:0] padIn
);
  logic [5:0] last_ff;
  always_ff @(posedge clk_sys)
    last_ff <= padIn;
  // Floating pin without pull shows no stale level
  always_comb
    for (int i = 0; i < 6; i++)
      padIn[i] = !pad.oeN[i] ? pad.out[i] : extEn[i] ? extVal[i]
        : pad.pdEn[i] ? 1'b0 : ~last_ff[i];
endmodule

// ==== dv/tb.sv ====
// Register and routing tests of the pin mux
`timescale 1ns/1ps
module tb;
  import spm_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  spm_apb_req_t apbReq = '0;
  spm_apb_rsp_t apbRsp;
  spm_pad6_t portOnePad, portZeroPad, addrPad;
  logic [5:0] portOnePadIn, portZeroPadIn, addrPadIn;
  logic [5:0] zeroExtEn = 6'h00;
  spm_drv6_t cardOneDrv = {6'h15, 6'h3F}, spiDrv = {6'h2A, 6'h3F}, gpioLowDrv = {6'h33, 6'h0F};
  spm_drv6_t cardZeroDrv = {6'h21, 6'h3F}, gpioZeroDrv = {6'h3C, 6'h3F};
  spm_drv6_t bufDrv = {6'h1E, 6'h3F}, gpioUpperDrv = {6'h2D, 6'h3F};
  spm_drv4_t audioDrv = {4'h9, 4'hF};
  logic [5:0] extMemUpperAddress = 6'h12;
  logic [5:0] cardOneIn, spiIn, gpioLowIn, cardZeroIn, gpioZeroIn, gpioUpperIn;
  logic [3:0] audioIn;
  logic [4:0] bufIn;
  logic bufRxClk, bufSrcClk, er;
  logic [15:0] rd;
  logic [5:0] oneOut [4] = '{6'h15, 6'h2A, 6'h33, 6'h00};
  logic [5:0] oneOeN [4] = '{6'h00, 6'h00, 6'h30, 6'h3F};
  logic [5:0] zeroOut [4] = '{6'h21, 6'h39, 6'h3C, 6'h1E};
  int n_fail = 0;
  int checks_done = 0;
  spm_pin_mux i_dut (.clk_sys, .resetn, .apbReq, .apbRsp, .portOnePadIn, .portOnePad,
    .portZeroPadIn, .portZeroPad, .addrPadIn, .addrPad, .cardOneDrv, .cardOneIn, .spiDrv,
    .spiIn, .gpioLowDrv, .gpioLowIn, .cardZeroDrv, .cardZeroIn, .audioDrv, .audioIn,
    .gpioZeroDrv, .gpioZeroIn, .bufDrv, .bufIn, .bufRxClk, .bufSrcClk, .extMemUpperAddress,
    .gpioUpperDrv, .gpioUpperIn);
  spm_pad_model i_one (.clk_sys, .pad(portOnePad), .extVal(6'h00), .extEn(6'h00),
    .padIn(portOnePadIn));
  spm_pad_model i_zero (.clk_sys, .pad(portZeroPad), .extVal(6'h20), .extEn(zeroExtEn),
    .padIn(portZeroPadIn));
  spm_pad_model i_addr (.clk_sys, .pad(addrPad), .extVal(6'h00), .extEn(6'h00),
    .padIn(addrPadIn));
  initial
    forever #4 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    apbReq <= {a, 1'b1, 1'b0, w, 16'h0000, d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata[15:0];
    er = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    wt(5);
    chk("rstPad", {portOnePad.oeN, portZeroPad.pdEn, addrPad.oeN}, 18'h3FFFF);
    wt(3);
    resetn <= 1'b1;
    foreach (oneOut[a])
    begin
      apb(1'b0, 18'h07000 + 18'(a) * 18'h0005C / 18'h5C * 18'h0, 16'h0000);
    end
    apb(1'b0, 18'h07000, 16'h0000);
    chk("busSelRst", rd, 16'h0000);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, 18'h07000, 16'(m << 10));
      wt(5);
      chk("oneOeN", portOnePad.oeN, oneOeN[m]);
      chk("oneOut", portOnePad.out & ~oneOeN[m], oneOut[m] & ~oneOeN[m]);
      chk("spiIn", spiIn, m == 1 ? 6'h2A : 6'h00);
      chk("cardOneIn", cardOneIn, m == 0 ? 6'h15 : 6'h00);
      chk("gpioLowIn", gpioLowIn, m == 2 ? 6'h03 : 6'h00);
      apb(1'b1, 18'h07000, 16'(m << 8));
      wt(5);
      chk("zeroOut", portZeroPad.out, zeroOut[m]);
      chk("audioIn", audioIn, m == 1 ? 4'h9 : 4'h0);
      chk("cardZeroIn", cardZeroIn, m == 0 ? 6'h21 : 6'h00);
      chk("gpioZeroIn", gpioZeroIn, m == 1 ? 6'h30 : m == 2 ? 6'h3C : 6'h00);
      chk("bufIn", bufIn, m == 3 ? 5'h1E : 5'h00);
    end
    apb(1'b1, 18'h07000, 16'h0005);
    wt(5);
    chk("addrOut", addrPad.out, 6'h17);
    chk("gpioUpIn", gpioUpperIn, 6'h05);
    apb(1'b1, 18'h0705C, 16'hFFFF);
    apb(1'b1, 18'h07060, 16'h0029);
    apb(1'b0, 18'h0705C, 16'h0000);
    chk("inhOne", rd, 16'h3F3F);
    wt(3);
    chk("pdEn", {portOnePad.pdEn, portZeroPad.pdEn, addrPad.pdEn}, 18'h00016);
    apb(1'b1, 18'h07000, 16'hFFFF);
    apb(1'b0, 18'h07000, 16'h0000);
    chk("busSel", rd, 16'h8F3F);
    bufDrv.drv <= 6'h1F;
    zeroExtEn <= 6'h20;
    apb(1'b1, 18'h07000, 16'h8300);
    wt(6);
    chk("srcClk", {bufSrcClk, bufRxClk}, 2'b10);
    apb(1'b1, 18'h07000, 16'h0300);
    wt(6);
    chk("rxClk", {bufSrcClk, bufRxClk}, 2'b01);
    apb(1'b0, 18'h00040, 16'h0000);
    chk("unmapped", {er, rd}, 17'h10000);
    apb(1'b1, 18'h07004, 16'h0001);
    chk("levelWr", er, 1'b1);
    tally_and_finish();
  end
  initial
  begin
    wt(5000);
    n_fail++;
    tally_and_finish();
  end
endmodule
